// ==== framer_rx_model.sv ====
// Behavioural framer that serialises one byte into a chosen Sa bit or time slot
`timescale 1ns/1ps
`default_nettype none

module framer_rx_model (
    input  wire logic                       ref_clk_in,
    input  wire logic                       sys_rst_in,
    input  wire logic                       go_in,
    input  wire logic [7:0]                 byte_in,
    input  wire logic                       is_sa_in,
    input  wire logic [4:0]                 id_in,
    output hdlc_rx_route_pkg::rx_bit_t      bit_out,
    output logic                            busy_out
);
    logic [7:0] shift_reg;
    logic [3:0] left_reg;

    // ----------------------------------------------------------------
    // Bit source
    // ----------------------------------------------------------------
    // Line order is least significant bit first
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            left_reg <= 4'h0;
            bit_out  <= '0;
        end else if (go_in && left_reg == 4'h0) begin
            shift_reg      <= byte_in;
            left_reg       <= 4'h8;
            bit_out.valid  <= 1'b0;
            bit_out.is_sa  <= is_sa_in;
            bit_out.sa_idx <= id_in[2:0];
            bit_out.slot   <= id_in;
        end else if (left_reg != 4'h0) begin
            bit_out.valid <= 1'b1;
            bit_out.data  <= shift_reg[0];
            shift_reg     <= shift_reg >> 1;
            left_reg      <= left_reg - 4'h1;
        end else begin
            // Toggle so a stray sample never looks like held data
            bit_out.valid <= 1'b0;
            bit_out.data  <= ~bit_out.data;
        end
    end

    assign busy_out = (left_reg != 4'h0) || bit_out.valid;
endmodule

`default_nettype wire

// ==== hdlc_fifo_rx_routing.sv ====
// HDLC host FIFO ports, transmit information flags and receive bit routing
`timescale 1ns/1ps
`default_nettype none

module hdlc_fifo_rx_routing #(
    parameter int DEPTH = hdlc_rx_route_pkg::FIFO_DEPTH_DEFAULT
) (
    input  wire logic                         ref_clk_in,
    input  wire logic                         sys_rst_in,
    input  wire hdlc_rx_route_pkg::host_req_t host_req_in,
    output logic [7:0]                        host_rdata_out,
    output logic                              host_rvalid_out,
    input  wire hdlc_rx_route_pkg::rx_bit_t   rx_bit_in,
    input  wire logic [4:0]                   rx_control_two_in,
    input  wire logic [31:0]                  rx_channel_block_regs_in,
    input  wire logic                         tx_end_of_message_in,
    output logic                              tx_eom_clear_out,
    input  wire logic                         tx_byte_req_in,
    output logic [7:0]                        tx_byte_out,
    output logic                              tx_byte_valid_out,
    output logic                              tx_abort_out,
    output logic                              rx_byte_lost_out
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_CNT  = (AW+1)'(1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][7:0] rx_mem;
        logic [AW-1:0]         rx_wp;
        logic [AW-1:0]         rx_rp;
        logic [AW:0]           rx_cnt;
        logic [DEPTH-1:0][7:0] tx_mem;
        logic [AW-1:0]         tx_wp;
        logic [AW-1:0]         tx_rp;
        logic [AW:0]           tx_cnt;
        logic                  udr;
        logic                  in_msg;
        logic [7:0]            routing;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [7:0]            shift;
        logic [2:0]            nbits;
        logic [1:0][7:0]       skid;
        logic [1:0]            skid_cnt;
        logic [7:0]            tx_byte;
        logic                  tx_valid;
        logic                  abort;
        logic                  eom_clr;
        logic                  lost;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ----------------------------------------------------------------
    // Decode and routing
    // ----------------------------------------------------------------
    logic       rd_rx;
    logic       rd_info;
    logic       rd_route;
    logic       wr_tx;
    logic       wr_route;
    logic       take_bit;
    logic [4:0] sa_mask;
    logic [4:0] chan_sel;
    logic       sa_hit;
    logic       slot_hit;
    logic       tx_pop;
    logic       tx_push;
    logic       udr_set;
    logic       skid_push;
    logic       skid_pop;
    logic       rx_pop;
    logic [7:0] byte_done;
    logic       byte_ready;
    logic [7:0] rx_head;
    logic [7:0] info_value;

    always_comb begin
        rd_rx    = host_req_in.rd && host_req_in.addr == hdlc_rx_route_pkg::RX_PACKET_BYTE_PORT_ADDR;
        rd_info  = host_req_in.rd && host_req_in.addr == hdlc_rx_route_pkg::TX_FIFO_INFO_ADDR;
        rd_route = host_req_in.rd && host_req_in.addr == hdlc_rx_route_pkg::RX_LINK_ROUTING_CTRL_ADDR;
        wr_tx    = host_req_in.wr && host_req_in.addr == hdlc_rx_route_pkg::TX_PACKET_BYTE_PORT_ADDR;
        wr_route = host_req_in.wr && host_req_in.addr == hdlc_rx_route_pkg::RX_LINK_ROUTING_CTRL_ADDR;

        // Source of the Sa enable mask: second receive control or routing register
        chan_sel = state_reg.routing[hdlc_rx_route_pkg::RX_CHANNEL_SEL_MSB:hdlc_rx_route_pkg::RX_CHANNEL_SEL_LSB];
        sa_mask  = state_reg.routing[hdlc_rx_route_pkg::RX_SOURCE_SELECT_POS] ? chan_sel
                                                                               : rx_control_two_in;
        // Mask bit 4 enables Sa4 (index 0) down to bit 0 for Sa8
        sa_hit = 1'b0;
        if (rx_bit_in.sa_idx < 3'(hdlc_rx_route_pkg::SA_COUNT)) begin
            sa_hit = rx_bit_in.is_sa && sa_mask[3'(4) - rx_bit_in.sa_idx];
        end
        slot_hit = state_reg.routing[hdlc_rx_route_pkg::RX_SLOT_MODE_POS]
                   ? rx_channel_block_regs_in[rx_bit_in.slot]
                   : rx_bit_in.slot == chan_sel;
        take_bit = 1'b0;
        if (rx_bit_in.valid) begin
            if (!state_reg.routing[hdlc_rx_route_pkg::RX_SOURCE_SELECT_POS]) begin
                take_bit = sa_hit;
            end else if (state_reg.routing[hdlc_rx_route_pkg::RX_SPARE_OR_SLOT_POS]) begin
                take_bit = !rx_bit_in.is_sa && slot_hit;
            end else begin
                take_bit = sa_hit;
            end
        end

        // Line order is least significant bit first
        byte_done  = {rx_bit_in.data, state_reg.shift[7:1]};
        byte_ready = take_bit && state_reg.nbits == 3'h7;

        // Two-entry skid buffer between assembler and receive FIFO
        skid_pop  = state_reg.skid_cnt != 2'h0 && state_reg.rx_cnt != FULL_CNT;
        skid_push = byte_ready && (state_reg.skid_cnt != 2'(hdlc_rx_route_pkg::SKID_DEPTH) || skid_pop);
        rx_pop    = rd_rx && state_reg.rx_cnt != '0;
        rx_head   = state_reg.rx_mem[state_reg.rx_rp];

        tx_pop  = tx_byte_req_in && state_reg.tx_cnt != '0;
        tx_push = wr_tx && state_reg.tx_cnt != FULL_CNT;
        // Dry FIFO mid-message without end-of-message marks underrun
        udr_set = tx_byte_req_in && state_reg.tx_cnt == '0 && state_reg.in_msg
                  && !tx_end_of_message_in;

        // Unassigned bits read as zero
        info_value = 8'h00;
        info_value[hdlc_rx_route_pkg::TX_FIFO_EMPTY_FLAG_POS] = state_reg.tx_cnt == '0;
        info_value[hdlc_rx_route_pkg::TX_FIFO_FULL_FLAG_POS]  = state_reg.tx_cnt == FULL_CNT;
        info_value[hdlc_rx_route_pkg::TX_UNDERRUN_FLAG_POS]   = state_reg.udr;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next          = state_reg;
        state_next.rvalid   = host_req_in.rd;
        state_next.tx_valid = 1'b0;
        state_next.abort    = 1'b0;
        state_next.eom_clr  = 1'b0;
        state_next.lost     = byte_ready && !skid_push;

        // Host read port
        if (rd_rx) begin
            state_next.rdata = rx_pop ? rx_head : hdlc_rx_route_pkg::READ_IDLE;
        end else if (rd_info) begin
            state_next.rdata = info_value;
        end else if (rd_route) begin
            state_next.rdata = state_reg.routing;
        end else if (host_req_in.rd) begin
            state_next.rdata = hdlc_rx_route_pkg::READ_IDLE;
        end
        if (wr_route) begin
            state_next.routing = host_req_in.wdata;
        end

        // Underrun flag: a new event beats the read clear
        if (udr_set) begin
            state_next.udr = 1'b1;
        end else if (rd_info) begin
            state_next.udr = 1'b0;
        end

        // Transmit FIFO
        if (tx_push) begin
            state_next.tx_mem[state_reg.tx_wp] = host_req_in.wdata;
            state_next.tx_wp = state_reg.tx_wp + AW'(1);
        end
        if (tx_pop) begin
            state_next.tx_byte  = state_reg.tx_mem[state_reg.tx_rp];
            state_next.tx_valid = 1'b1;
            state_next.tx_rp    = state_reg.tx_rp + AW'(1);
            state_next.in_msg   = 1'b1;
            // Last byte of message leaves: hand end-of-message back
            if (tx_end_of_message_in && state_reg.tx_cnt == ONE_CNT && !tx_push) begin
                state_next.eom_clr = 1'b1;
                state_next.in_msg  = 1'b0;
            end
        end
        if (udr_set) begin
            state_next.abort  = 1'b1;
            state_next.in_msg = 1'b0;
        end
        state_next.tx_cnt = state_reg.tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);

        // Bit assembly; a byte with no room is dropped and flagged
        if (take_bit) begin
            state_next.shift = byte_done;
            state_next.nbits = state_reg.nbits + 3'h1;
        end
        if (skid_pop) begin
            state_next.rx_mem[state_reg.rx_wp] = state_reg.skid[0];
            state_next.rx_wp   = state_reg.rx_wp + AW'(1);
            state_next.skid[0] = state_reg.skid[1];
        end
        if (skid_push) begin
            if (state_reg.skid_cnt == 2'h0 || (state_reg.skid_cnt == 2'h1 && skid_pop)) begin
                state_next.skid[0] = byte_done;
            end else begin
                state_next.skid[1] = byte_done;
            end
        end
        state_next.skid_cnt = state_reg.skid_cnt + 2'(skid_push) - 2'(skid_pop);
        if (rx_pop) begin
            state_next.rx_rp = state_reg.rx_rp + AW'(1);
        end
        state_next.rx_cnt = state_reg.rx_cnt + (AW+1)'(skid_pop) - (AW+1)'(rx_pop);
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg         <= '0;
            state_reg.routing <= hdlc_rx_route_pkg::ROUTING_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        host_rdata_out    = state_reg.rdata;
        host_rvalid_out   = state_reg.rvalid;
        tx_byte_out       = state_reg.tx_byte;
        tx_byte_valid_out = state_reg.tx_valid;
        tx_abort_out      = state_reg.abort;
        tx_eom_clear_out  = state_reg.eom_clr;
        rx_byte_lost_out  = state_reg.lost;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [AW:0] tx_cnt_q;
    logic        tx_empty_q;
    logic        tx_full_q;

    always_comb begin
        tx_cnt_q   = state_reg.tx_cnt;
        tx_empty_q = state_reg.tx_cnt == '0;
        tx_full_q  = state_reg.tx_cnt == FULL_CNT;
    end

    property p_rx_read_data;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rx_pop |=> host_rvalid_out && host_rdata_out == $past(rx_head);
    endproperty
    a_rx_read_data: assert property (p_rx_read_data) else $error("receive byte read mismatch");

    property p_tx_push_count;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_tx && !tx_full_q && !tx_byte_req_in |=> tx_cnt_q == $past(tx_cnt_q) + (AW+1)'(1);
    endproperty
    a_tx_push_count: assert property (p_tx_push_count) else $error("transmit write not stored");

    property p_info_empty;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rd_info |=> host_rdata_out[2] == $past(tx_empty_q) && host_rdata_out[7:3] == 5'h00;
    endproperty
    a_info_empty: assert property (p_info_empty) else $error("empty flag wrong");

    property p_info_full;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rd_info |=> host_rdata_out[1] == $past(tx_full_q);
    endproperty
    a_info_full: assert property (p_info_full) else $error("full flag wrong");

    property p_underrun_abort;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        udr_set |=> state_reg.udr && tx_abort_out ##1 !tx_abort_out;
    endproperty
    a_underrun_abort: assert property (p_underrun_abort) else $error("underrun without abort");

    property p_underrun_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        state_reg.udr && !rd_info |=> state_reg.udr;
    endproperty
    a_underrun_hold: assert property (p_underrun_hold) else $error("underrun dropped early");

    property p_underrun_clear;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rd_info && !udr_set |=> !state_reg.udr;
    endproperty
    a_underrun_clear: assert property (p_underrun_clear) else $error("underrun not cleared by read");

    property p_full_write_ignored;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_tx && tx_full_q && !tx_byte_req_in |=> tx_cnt_q == $past(tx_cnt_q);
    endproperty
    a_full_write_ignored: assert property (p_full_write_ignored) else $error("write to full FIFO");

    property p_sa_default;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rx_bit_in.valid && !state_reg.routing[7] && rx_bit_in.is_sa && rx_bit_in.sa_idx == 3'h0
        |-> take_bit == rx_control_two_in[4];
    endproperty
    a_sa_default: assert property (p_sa_default) else $error("Sa4 routing wrong");

    property p_single_slot;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rx_bit_in.valid && state_reg.routing[7:5] == 3'b110 && !rx_bit_in.is_sa
        |-> take_bit == (rx_bit_in.slot == state_reg.routing[4:0]);
    endproperty
    a_single_slot: assert property (p_single_slot) else $error("single slot routing wrong");

    property p_eom_clear;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        tx_pop && tx_end_of_message_in && tx_cnt_q == ONE_CNT && !tx_push |=> tx_eom_clear_out && !state_reg.in_msg;
    endproperty
    a_eom_clear: assert property (p_eom_clear) else $error("end of message not returned");

    property p_byte_complete;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        byte_ready && state_reg.skid_cnt == 2'h0 |=> state_reg.skid[0] == $past(byte_done);
    endproperty
    a_byte_complete: assert property (p_byte_complete) else $error("assembled byte wrong");

    property p_sa_routing_reg;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rx_bit_in.valid && state_reg.routing[7:6] == 2'h2 && rx_bit_in.is_sa && rx_bit_in.sa_idx == 3'h1
        |-> take_bit == state_reg.routing[3];
    endproperty
    a_sa_routing_reg: assert property (p_sa_routing_reg) else $error("Sa5 routing wrong");

    property p_slot_mode_no_sa;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        state_reg.routing[7:6] == 2'h3 && rx_bit_in.is_sa |-> !take_bit;
    endproperty
    a_slot_mode_no_sa: assert property (p_slot_mode_no_sa) else $error("Sa bit taken in slot mode");

    property p_block_slots;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rx_bit_in.valid && state_reg.routing[7:5] == 3'h7 && !rx_bit_in.is_sa
        |-> take_bit == rx_channel_block_regs_in[rx_bit_in.slot];
    endproperty
    a_block_slots: assert property (p_block_slots) else $error("block slot routing wrong");

    c_underrun: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) udr_set);
    c_tx_full: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) tx_full_q && wr_tx);
    c_block_mode: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state_reg.routing[7:5] == 3'b111 && take_bit);
    c_rx_read: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) rx_pop);
    c_sa_reg_mode: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state_reg.routing[7:6] == 2'h2 && take_bit);

endmodule

`default_nettype wire

// ==== hdlc_rx_route_pkg.sv ====
// Constants and carrier types for the HDLC FIFO ports and receive routing block
// Overview of operation
// - Read at B4 returns next received byte, bit 7 MSB, bit 0 LSB.
// - Write at B7 pushes one byte into transmit FIFO, bit 7 MSB.
// - Transmit info bits 7..3 unassigned; host ignores them.
// - Transmit info bit 2 is live high while transmit FIFO empty.
// - Transmit info bit 1 is live high while transmit FIFO full.
// - Underrun bit 0 sets when transmit FIFO runs dry without end-of-message.
// - On underrun the transmitter sends an abort automatically.
// - Underrun stays set until host reads transmit info; that read clears it.
// - Routing bit 7 low: Sa bits from second receive control; high: routing register decides.
// - Routing bit 6 low: Sa bits, select bits 4..0 enable Sa4..Sa8.
// - Routing bit 6 high: DS0 slot bits feed the controller, mode by bit 5.
// - Mode bit 5 low: five-bit field picks exactly one time slot.
// - Mode bit 5 high: channel-block registers pick the time slots.
// - Single-channel field is bits 4..0, binary, bit 4 most significant.
// - Host sets end-of-message before last byte; controller clears it once sent.
package hdlc_rx_route_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] RX_PACKET_BYTE_PORT_ADDR  = 8'hB4;
    localparam logic [7:0] TX_FIFO_INFO_ADDR         = 8'hB6;
    localparam logic [7:0] TX_PACKET_BYTE_PORT_ADDR  = 8'hB7;
    localparam logic [7:0] RX_LINK_ROUTING_CTRL_ADDR = 8'hB8;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int TX_FIFO_EMPTY_FLAG_POS = 2;
    localparam int TX_FIFO_FULL_FLAG_POS  = 1;
    localparam int TX_UNDERRUN_FLAG_POS   = 0;
    localparam int RX_SOURCE_SELECT_POS   = 7;
    localparam int RX_SPARE_OR_SLOT_POS   = 6;
    localparam int RX_SLOT_MODE_POS       = 5;
    localparam int RX_CHANNEL_SEL_MSB     = 4;
    localparam int RX_CHANNEL_SEL_LSB     = 0;
    localparam logic [7:0] ROUTING_RESET  = 8'h00;
    localparam logic [7:0] READ_IDLE      = 8'h00;
    localparam int SA_COUNT               = 5;
    localparam int SLOT_COUNT             = 32;
    localparam int FIFO_DEPTH_DEFAULT     = 64;
    localparam int SKID_DEPTH             = 2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // One framer receive bit; sa_idx 0..4 means Sa4..Sa8
    typedef struct packed {
        logic       valid;
        logic       data;
        logic       is_sa;
        logic [2:0] sa_idx;
        logic [4:0] slot;
    } rx_bit_t;

endpackage

// ==== test_hdlc_fifo_rx_routing.sv ====
// Self-checking bench for the HDLC FIFO ports and receive routing
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("Error %s expected %0h seen %0h", nm, e, g); end end

module test_hdlc_fifo_rx_routing;
    logic                          ref_clk, sys_rst, rvalid, eom, eom_clr, eom_seen, tx_req, tx_valid, tx_abort;
    logic                          go, busy, sa, eom_set, lost, lost_seen;
    logic [7:0]                    rdata, tx_byte, sbyte;
    logic [4:0]                    ctl_two, sid;
    logic [31:0]                   blk;
    hdlc_rx_route_pkg::host_req_t  host_req;
    hdlc_rx_route_pkg::rx_bit_t    rx_bit;
    int                            fails, n_tests;

    hdlc_fifo_rx_routing #(.DEPTH(4)) hdlc_fifo_rx_routing_i (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst),
        .host_req_in(host_req), .host_rdata_out(rdata), .host_rvalid_out(rvalid), .rx_bit_in(rx_bit),
        .rx_control_two_in(ctl_two), .rx_channel_block_regs_in(blk), .tx_end_of_message_in(eom),
        .tx_eom_clear_out(eom_clr), .tx_byte_req_in(tx_req), .tx_byte_out(tx_byte),
        .tx_byte_valid_out(tx_valid), .tx_abort_out(tx_abort), .rx_byte_lost_out(lost));
    framer_rx_model framer_rx_model_i (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .go_in(go), .byte_in(sbyte),
        .is_sa_in(sa), .id_in(sid), .bit_out(rx_bit), .busy_out(busy));

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        host_req.rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        host_req.wr <= 1'b0;
    endtask

    task automatic pop(input logic [7:0] e, input logic ev, input logic ea);
        @(posedge ref_clk);
        tx_req <= 1'b1;
        @(posedge ref_clk);
        tx_req <= 1'b0;
        #1;
        `CHK("tx_valid", ev, tx_valid)
        `CHK("tx_abort", ea, tx_abort)
        if (ev) `CHK("tx_byte", e, tx_byte)
    endtask

    task automatic send(input logic [7:0] b, input logic s, input logic [4:0] id);
        @(posedge ref_clk);
        {go, sbyte, sa, sid} <= {1'b1, b, s, id};
        @(posedge ref_clk);
        go <= 1'b0;
        for (int k = 0; k <= 40; k++) begin
            @(posedge ref_clk);
            #1;
            if (!busy) break;
            if (k == 40) begin
                fails++;
                wrap_up();
            end
        end
        repeat (4) @(posedge ref_clk);
    endtask

    // Far-side end-of-message bit and sticky event monitors, one driver each
    always @(posedge ref_clk) begin
        eom       <= !sys_rst && !eom_clr && (eom || eom_set);
        eom_seen  <= !sys_rst && (eom_seen || eom_clr);
        lost_seen <= !sys_rst && (lost_seen || lost);
    end

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        static logic [7:0] rt [4] = '{8'h00, 8'h88, 8'hD3, 8'hF3};
        static logic       ts [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        static logic [4:0] wid [4] = '{5'd1, 5'd0, 5'd25, 5'd19};
        static logic [4:0] rid [4] = '{5'd0, 5'd1, 5'd19, 5'd7};
        {sys_rst, host_req, eom_set, tx_req, go, sbyte, sa, sid} = '0;
        sys_rst = 1'b1;
        {fails, n_tests} = '0;
        ctl_two = 5'b10000;
        blk = 32'h0000_0080;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdc(8'hB8, 8'h00);
        rdc(8'hB6, 8'h04);
        rdc(8'hB4, 8'h00);
        rdc(8'hB5, 8'h00);
        rdc(8'hB7, 8'h00);
        // Routing modes: each rejects a decoy byte, keeps the routed one
        for (int i = 0; i < 4; i++) begin
            wr(8'hB8, rt[i]);
            rdc(8'hB8, rt[i]);
            send(8'hFF, ts[i], wid[i]);
            send(8'h16 + 8'(i * 33), ts[i], rid[i]);
            rdc(8'hB4, 8'h16 + 8'(i * 33));
            rdc(8'hB4, 8'h00);
        end
        // Block mode still on slot 7: an Sa decoy there must be refused
        send(8'hFF, 1'b1, 5'd7);
        // Fill receive FIFO and skid buffer, then overflow by one byte
        for (int i = 0; i < 7; i++) begin
            if (i == 6) `CHK("lost_early", 1'b0, lost_seen)
            send(8'hA0 + 8'(i), 1'b0, 5'd7);
        end
        `CHK("rx_lost", 1'b1, lost_seen)
        for (int i = 0; i < 6; i++) rdc(8'hB4, 8'hA0 + 8'(i));
        rdc(8'hB4, 8'h00);
        for (int i = 0; i < 4; i++) wr(8'hB7, 8'hC0 + 8'(i));
        rdc(8'hB6, 8'h02);
        wr(8'hB7, 8'hEE);
        for (int i = 0; i < 4; i++) pop(8'hC0 + 8'(i), 1'b1, 1'b0);
        pop(8'h00, 1'b0, 1'b1);
        rdc(8'hB6, 8'h05);
        rdc(8'hB6, 8'h04);
        @(posedge ref_clk);
        eom_set <= 1'b1;
        @(posedge ref_clk);
        eom_set <= 1'b0;
        wr(8'hB7, 8'h5A);
        pop(8'h5A, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        `CHK("eom_clear", 1'b1, eom_seen)
        `CHK("eom_bit", 1'b0, eom)
        pop(8'h00, 1'b0, 1'b0);
        rdc(8'hB6, 8'h04);
        wrap_up();
    end
endmodule

`default_nettype wire
